// >>> rtl/ccs_regs.svh
// Purpose: Register offsets, field positions and reset values of the comparator control block
// Assumes: APB with 32-bit data, word-aligned registers
// Notes: Included by the top design module
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

`define CCS_OFF_CTRL0 12'h000
`define CCS_OFF_CTRL1 12'h004
`define CCS_OFF_CTRL2 12'h008
`define CCS_OFF_STATUS 12'h00c
`define CCS_OFF_IMASK 12'h010

`define CCS_CTRL_EN 0
`define CCS_CTRL_IE 1
`define CCS_CTRL_HYS 2
`define CCS_CTRL_PSEL 3
`define CCS_CTRL_NSEL 4
`define CCS_CTRL_INV 6
`define CCS_CTRL_MASK 7'h5f
`define CCS_CTRL2_MASK 7'h57

`define CCS_ST_OP0 4
`define CCS_ST_OP1 5
`define CCS_ST_OUT0 8
`define CCS_ST_FLAG_MASK 6'h37
`define CCS_IMASK_RESET 6'h37

`define CCS_RESET_VAL 32'h0000_0000

`endif

// >>> rtl/ccs_pkg.sv
// Purpose: Types shared by the comparator control design files
// Assumes: Nothing beyond the register header
// Notes: Constants live in the header, types here
package ccs_pkg;

  typedef logic [6:0] ccs_ctrl_t;
  typedef enum logic {CCS_NEG_PIN, CCS_NEG_BANDGAP} ccs_neg_sel_t;

endpackage : ccs_pkg

// >>> rtl/ccs_sync.sv
// Purpose: Two-stage synchroniser for one asynchronous level
// Assumes: Input comes from analog logic outside the clock domain
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module ccs_sync
  import ccs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);

  logic meta_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : ccs_sync

// >>> rtl/ccs_chan.sv
// Purpose: One sampled channel with optional inversion and change detection
// Assumes: Input already synchronised
// Notes: Change pulse lasts one enabled cycle
`timescale 1ns/10ps
module ccs_chan
  import ccs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d_sync,
  input wire logic invert,
  output logic sample_r,
  output logic change
);

  logic sample_nxt;

  assign sample_nxt = d_sync ^ invert;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample_r <= 1'b0;
    end else if (ce) begin
      sample_r <= sample_nxt;
    end
  end

  // Current versus previous sample
  assign change = ce & (sample_nxt != sample_r);

endmodule : ccs_chan

// >>> rtl/ccs_top.sv
// Purpose: Control and status logic for three analog comparators and two buffer monitors
// Assumes: clk_sys is the gated peripheral clock; analog outputs are asynchronous
// Notes: APB slave, zero wait states, PSLVERR on unmapped addresses
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "ccs_regs.svh"
module ccs_top
  import ccs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cmp_raw_out,
  input wire logic [1:0] opamp_buf_out,
  output logic [2:0] cmp_enable,
  output logic [2:0] cmp_hysteresis_enable,
  output logic [1:0] cmp_positive_select,
  output logic [2:0] cmp_negative_select,
  output logic [2:0] cmp_sampled_output,
  output logic irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic acc;
  logic wr;
  logic sel_c0;
  logic sel_c1;
  logic sel_c2;
  logic sel_st;
  logic sel_im;
  logic mapped;
  logic full_low;

  assign acc = psel & penable & clk_en;
  assign wr = acc & pwrite;
  assign sel_c0 = (paddr == `CCS_OFF_CTRL0);
  assign sel_c1 = (paddr == `CCS_OFF_CTRL1);
  assign sel_c2 = (paddr == `CCS_OFF_CTRL2);
  assign sel_st = (paddr == `CCS_OFF_STATUS);
  assign sel_im = (paddr == `CCS_OFF_IMASK);
  assign mapped = sel_c0 | sel_c1 | sel_c2 | sel_st | sel_im;
  // Every writable field lives in byte lane 0
  assign full_low = pstrb[0];
  // Zero wait states; while the clock is gated off the bus just waits
  assign pready = clk_en;
  assign pslverr = psel & penable & ~mapped;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  ccs_ctrl_t ctrl_r [3];
  logic [5:0] imask_r;
  logic [2:0] ctrl_sel;

  assign ctrl_sel = {sel_c2, sel_c1, sel_c0};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        ctrl_r[i] <= ccs_ctrl_t'(`CCS_RESET_VAL);
      end
    end else if (wr && full_low) begin
      for (int i = 0; i < 2; i++) begin
        if (ctrl_sel[i]) begin
          ctrl_r[i] <= pwdata[6:0] & `CCS_CTRL_MASK;
        end
      end
      if (ctrl_sel[2]) begin
        ctrl_r[2] <= pwdata[6:0] & `CCS_CTRL2_MASK;
      end
    end
  end

  // Extra mask over the status layout; all sources pass after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      imask_r <= `CCS_IMASK_RESET;
    end else if (wr && full_low && sel_im) begin
      imask_r <= pwdata[5:0] & `CCS_ST_FLAG_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Analog side controls
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cmp_enable[i] = ctrl_r[i][`CCS_CTRL_EN];
      cmp_hysteresis_enable[i] = ctrl_r[i][`CCS_CTRL_HYS];
      cmp_negative_select[i] = ctrl_r[i][`CCS_CTRL_NSEL];
    end
    for (int i = 0; i < 2; i++) begin
      cmp_positive_select[i] = ctrl_r[i][`CCS_CTRL_PSEL];
    end
  end

  // ---------------------------------------------------------------
  // Sampling and change detection
  // ---------------------------------------------------------------
  // Raw output already reflects positive above negative in the analog core
  logic [4:0] raw_all;
  logic [4:0] sync_all;
  logic [4:0] inv_all;
  logic [4:0] samp_all;
  logic [4:0] chg_all;

  assign raw_all = {opamp_buf_out, cmp_raw_out};
  assign inv_all = {2'b00, ctrl_r[2][`CCS_CTRL_INV], ctrl_r[1][`CCS_CTRL_INV], ctrl_r[0][`CCS_CTRL_INV]};

  for (genvar g = 0; g < 5; g++) begin : g_chan
    ccs_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(clk_en),
      .d(raw_all[g]),
      .q(sync_all[g])
    );
    ccs_chan u_chan (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(clk_en),
      .d_sync(sync_all[g]),
      .invert(inv_all[g]),
      .sample_r(samp_all[g]),
      .change(chg_all[g])
    );
  end

  assign cmp_sampled_output = samp_all[2:0];

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic [5:0] flag_r;
  logic [5:0] flag_set;
  logic [5:0] flag_clr;

  assign flag_set = {chg_all[4], chg_all[3], 1'b0, chg_all[2:0]};
  assign flag_clr = (wr && full_low && sel_st) ? (pwdata[5:0] & `CCS_ST_FLAG_MASK) : 6'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 6'h00;
    end else if (clk_en) begin
      // Set wins so a change in the clearing cycle is kept
      flag_r <= (flag_r & ~flag_clr) | flag_set;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  logic [5:0] flag_en;

  // Buffer flags have no control bit, so only the mask gates them
  assign flag_en = {2'b11, 1'b0, ctrl_r[2][`CCS_CTRL_IE], ctrl_r[1][`CCS_CTRL_IE], ctrl_r[0][`CCS_CTRL_IE]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(flag_r & flag_en & imask_r);
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (1'b1)
      sel_c0: rd_nxt = {25'h0, ctrl_r[0]};
      sel_c1: rd_nxt = {25'h0, ctrl_r[1]};
      sel_c2: rd_nxt = {25'h0, ctrl_r[2]};
      sel_st: rd_nxt = {21'h0, samp_all[2:0], 2'b00, flag_r};
      sel_im: rd_nxt = {26'h0, imask_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Registered in the setup cycle so data is ready in the access phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

endmodule : ccs_top

// >>> testbench/ccs_chk.sv
// Purpose: Port-level checks of the comparator control block
// Assumes: One clock domain, reset asynchronous active low
// Notes: Bound into every instance of the top module
`timescale 1ns/10ps
module ccs_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic [2:0] cmp_raw_out,
  input wire logic [2:0] cmp_enable,
  input wire logic [2:0] cmp_hysteresis_enable,
  input wire logic [2:0] cmp_negative_select,
  input wire logic [1:0] cmp_positive_select,
  input wire logic [2:0] cmp_sampled_output,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic wr;
  assign wr = psel && penable && pwrite && pstrb[0] && clk_en;
  AST_UNMAPPED: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access without error");
  AST_MAPPED: assert property (psel && penable && paddr inside {12'h000, 12'h004, 12'h008, 12'h00c} |-> !pslverr)
    else $error("mapped access flagged");
  AST_EN0: assert property (wr && paddr == 12'h000 |=> cmp_enable[0] == $past(pwdata[0]))
    else $error("enable output wrong");
  AST_POS0: assert property (wr && paddr == 12'h000 |=> cmp_positive_select[0] == $past(pwdata[3]))
    else $error("positive select wrong");
  AST_HYS1: assert property (wr && paddr == 12'h004 |=> cmp_hysteresis_enable[1] == $past(pwdata[2]))
    else $error("hysteresis output wrong");
  AST_NEG2: assert property (wr && paddr == 12'h008 |=> cmp_negative_select[2] == $past(pwdata[4]))
    else $error("negative select wrong");
  // A sample may move only after a raw change passed the synchroniser, or after a write
  AST_SAMPLE: assert property ($changed(cmp_sampled_output) |-> $past(cmp_raw_out, 3) != $past(cmp_raw_out, 4) || $past(wr) || $past(wr, 2))
    else $error("sample changed without cause");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt dropped without a write");
endmodule : ccs_chk

bind ccs_top ccs_chk i_ccs_chk (.*);

// >>> testbench/ccs_analog_model.sv
// Purpose: Behavioural comparator and buffer cores
// Assumes: Bench sets which inputs sit above their references
// Notes: A disabled comparator reads low
`timescale 1ns/10ps
module ccs_analog_model (
  input wire logic [2:0] cmp_enable,
  input wire logic [1:0] cmp_positive_select,
  input wire logic [2:0] pin_above,
  input wire logic [1:0] opamp_level,
  output logic [2:0] cmp_raw_out,
  output logic [1:0] opamp_buf_out
);
  logic [2:0] pick_op;
  // Comparator 2 has its pin only
  assign pick_op = {1'b0, cmp_positive_select};
  assign cmp_raw_out = cmp_enable & ((pick_op & {1'b0, opamp_level}) | (~pick_op & pin_above));
  assign opamp_buf_out = opamp_level;
endmodule : ccs_analog_model

// >>> testbench/ccs_top_test.sv
// Purpose: Register and event tests of the comparator control block
// Assumes: Zero wait APB slave, clock enable high outside the gating test
// Notes: Sample path is three edges, interrupt one more
`timescale 1ns/10ps
module ccs_top_test;
  import ccs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  logic [2:0] cmp_raw_out, cmp_enable, cmp_hysteresis_enable, cmp_negative_select, cmp_sampled_output;
  logic [2:0] pin_above = 3'h0;
  logic [1:0] opamp_buf_out, cmp_positive_select;
  logic [1:0] opamp_level = 2'h0;
  logic clk_en = 1'b1;
  logic [3:0] pstrb = 4'hf;
  int bad_count = 0;
  int cmp_count = 0;

  always #4 clk_sys = ~clk_sys;

  ccs_top i_ccs_top (.*);
  ccs_analog_model i_ccs_analog_model (.*);

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd);
  endtask : rdc

  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Tests need well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rdc(12'(4 * i), 32'h0);
    rdc(12'h010, 32'h37);
    for (int i = 0; i < 3; i++) apb(1'b1, 12'(4 * i), 32'hffff_ffff);
    for (int i = 0; i < 3; i++) rdc(12'(4 * i), i == 2 ? 32'h57 : 32'h5f);
    chk("outs", 32'h7ff, {21'h0, cmp_positive_select, cmp_negative_select, cmp_hysteresis_enable, cmp_enable});
    for (int i = 0; i < 3; i++) apb(1'b1, 12'(4 * i), 32'h3);
    // Last control write lands at the edge the task returns on
    @(posedge clk_sys);
    chk("outs", 32'h007, {21'h0, cmp_positive_select, cmp_negative_select, cmp_hysteresis_enable, cmp_enable});
    repeat (4) @(posedge clk_sys);
    // Invert on then off toggled every comparator sample twice
    rdc(12'h00c, 32'h007);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h00c, 32'h0);
    rdc(12'h00c, 32'h007);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    rdc(12'h00c, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    pin_above <= 3'b101;
    repeat (5) @(posedge clk_sys);
    rdc(12'h00c, 32'h505);
    apb(1'b1, 12'h00c, 32'h5);
    rdc(12'h00c, 32'h500);
    apb(1'b1, 12'h008, 32'h1);
    pin_above <= 3'b001;
    repeat (5) @(posedge clk_sys);
    rdc(12'h00c, 32'h104);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h00c, 32'h4);
    apb(1'b1, 12'h010, 32'h0);
    pin_above <= 3'b000;
    repeat (5) @(posedge clk_sys);
    rdc(12'h00c, 32'h001);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h010, 32'h37);
    rdc(12'h00c, 32'h001);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h00c, 32'h1);
    opamp_level <= 2'b11;
    repeat (5) @(posedge clk_sys);
    rdc(12'h00c, 32'h030);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h00c, 32'h10);
    rdc(12'h00c, 32'h020);
    // Positive input taken from the op-amp, which sits high now
    apb(1'b1, 12'h000, 32'h0b);
    repeat (5) @(posedge clk_sys);
    rdc(12'h00c, 32'h121);
    chk("sampled", 32'h1, {29'h0, cmp_sampled_output});
    // Write without byte lane 0 must leave the register alone
    pstrb <= 4'he;
    apb(1'b1, 12'h000, 32'h0);
    pstrb <= 4'hf;
    rdc(12'h000, 32'h0b);
    // Inputs rise only while gated, so no change may ever be seen
    clk_en <= 1'b0;
    pin_above <= 3'b110;
    repeat (4) @(posedge clk_sys);
    chk("pready", 32'h0, {31'h0, pready});
    chk("sampled", 32'h1, {29'h0, cmp_sampled_output});
    clk_en <= 1'b1;
    pin_above <= 3'b000;
    rdc(12'h00c, 32'h121);
    rdc(12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    complete_run();
  end
endmodule : ccs_top_test
